// ==== bench/sfep_checker_sva.sv ====
`default_nettype none
module sfep_checker
    import sfep_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic [2:0]    BLOCK_PROTECT_FIELD,
    input  wire logic          LOCK_SCHEME_SELECT,
    input  wire logic          ANY_BLOCK_LOCKED,
    input  wire logic [7:0]    MEM_RDATA,
    input  wire logic          WRITE_ENABLE_LATCH,
    input  wire logic          READY_BUSY_FLAG,
    input  wire sfep_mem_req_t MEM_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence erase_all_s;
        MEM_REQ.erase && MEM_REQ.erase_kind == SFEP_ERASE_ALL;
    endsequence
    sequence busy_hold_s;
        READY_BUSY_FLAG [*8];
    endsequence
    chip_erase_start_a: assert property (
        erase_all_s |-> READY_BUSY_FLAG && !WRITE_ENABLE_LATCH
            && MEM_REQ.addr == 24'h000000)
        else $error("chip erase start wrong");
    erase_pulse_one_a: assert property (
        MEM_REQ.erase |=> !MEM_REQ.erase)
        else $error("erase pulse too long");
    erase_needs_wel_a: assert property (
        $rose(MEM_REQ.erase) |-> $past(WRITE_ENABLE_LATCH))
        else $error("erase without latch");
    chip_erase_prot_a: assert property (
        erase_all_s |-> BLOCK_PROTECT_FIELD == SFEP_BP_NONE
            && !(LOCK_SCHEME_SELECT && ANY_BLOCK_LOCKED))
        else $error("protected chip erased");
    erase_addr_mask_a: assert property (
        MEM_REQ.erase |-> (MEM_REQ.erase_kind == SFEP_ERASE_4K
            ? (MEM_REQ.addr & ~SFEP_MASK_4K) == 24'h0
            : MEM_REQ.erase_kind == SFEP_ERASE_32K
            ? (MEM_REQ.addr & ~SFEP_MASK_32K) == 24'h0
            : (MEM_REQ.addr & ~SFEP_MASK_64K) == 24'h0))
        else $error("erase address not masked");
    erase_busy_hold_a: assert property (
        MEM_REQ.erase |=> busy_hold_s)
        else $error("busy dropped in erase");
    prog_while_busy_a: assert property (
        MEM_REQ.we |-> READY_BUSY_FLAG)
        else $error("write outside timed work");
    busy_wel_clear_a: assert property (
        READY_BUSY_FLAG |-> !WRITE_ENABLE_LATCH)
        else $error("latch set while busy");
    prog_and_only_a: assert property (
        MEM_REQ.we |-> (MEM_REQ.wdata & ~$past(MEM_RDATA)) == 8'h00)
        else $error("program set a bit");
    busy_ends_a: assert property (
        $rose(READY_BUSY_FLAG) |-> ##[1:1000] !READY_BUSY_FLAG)
        else $error("busy never ends");
endmodule
`default_nettype wire

// ==== bench/sfep_host_model.sv ====
`default_nettype none
module sfep_host_model
    import sfep_pkg::*;
(
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // half of the 160 ns serial period, launched just after a clock edge
    task automatic half();
        repeat (16) @(posedge clk);
        #1;
    endtask
    // whole bytes msb first, then tail extra bits of ones; clock idles low
    task automatic frame(input logic [7:0] q[$], input int tail);
        int i;
        int n;
        n = q.size() * 8 + tail;
        half();
        cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            si = (i / 8 < q.size()) ? q[i / 8][7 - i % 8]
                                    : 1'b1;
            half();
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        si   = ~si;
    endtask
endmodule
`default_nettype wire

// ==== bench/test_serial_flash_erase_program.sv ====
`default_nettype none
module test_serial_flash_erase_program
    import sfep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    logic          cs_n, sck, si, lss = 1'b0, abl = 1'b0, prot = 1'b0;
    logic [2:0]    bp = 3'h0;
    logic [7:0]    rdata = 8'h00;
    logic [7:0]    mem [0:255];
    logic          write_enable_latch, busy;
    logic [23:0]   paddr;
    sfep_mem_req_t req;
    logic [1:0]    e_kind;
    logic [23:0]   e_addr;
    int            mismatches = 0, checks_done = 0, n_erase = 0, n_we = 0;
    always #2.5 clk = ~clk;
    sfep_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
    sfep_sequencer #(.BLOCK_ERASE_CYCLES(50), .CHIP_ERASE_CYCLES(800),
        .PAGE_PROGRAM_CYCLES(60), .BYTE_PROGRAM_CYCLES(20)) dut (
        .CLK(clk), .RESET(reset), .CS_N(cs_n), .SCK(sck), .SI(si),
        .BLOCK_PROTECT_FIELD(bp), .LOCK_SCHEME_SELECT(lss),
        .ANY_BLOCK_LOCKED(abl), .ADDR_PROTECTED(prot), .MEM_RDATA(rdata),
        .WRITE_ENABLE_LATCH(write_enable_latch), .READY_BUSY_FLAG(busy),
        .PROT_ADDR(paddr), .MEM_REQ(req));
    // ------------------------------------------------------------
    // array model and pulse monitor
    // ------------------------------------------------------------
    initial foreach (mem[i]) mem[i] = 8'hDB;
    always @(posedge clk) begin
        if (req.erase === 1'b1) begin
            n_erase++;
            e_kind = req.erase_kind;
            e_addr = req.addr;
        end
        if (req.we === 1'b1) begin
            n_we++;
            mem[req.addr[7:0]] <= req.wdata;
        end
        rdata <= mem[req.addr[7:0]];
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d of %0d checks", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
        check(busy, 1'b0);
    endtask
    task automatic wren();
        host.frame({SFEP_OP_WRITE_ENABLE}, 0);
        settle();
        check(write_enable_latch, 1'b1);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_chip_erase();
        logic [7:0] ops [2];
        int n0;
        ops = '{SFEP_OP_CHIP_ERASE_A, SFEP_OP_CHIP_ERASE_B};
        foreach (ops[i]) begin
            wren();
            n0 = n_erase;
            host.frame({ops[i]}, 0);
            settle();
            check(n_erase, n0 + 1);
            check(e_kind, SFEP_ERASE_ALL);
            check({busy, write_enable_latch}, 2'b10);
            host.frame({SFEP_OP_SUSPEND}, 0);
            settle();
            check(busy, 1'b1);
            wait_idle();
        end
    endtask
    task automatic t_block_erase();
        logic [7:0]  ops [3];
        logic [23:0] exp [3];
        int n0;
        ops = '{SFEP_OP_ERASE_4K, SFEP_OP_ERASE_32K, SFEP_OP_ERASE_64K};
        exp = '{24'h123000, 24'h120000, 24'h120000};
        foreach (ops[i]) begin
            wren();
            n0 = n_erase;
            host.frame({ops[i], 8'h12, 8'h34, 8'h56}, 0);
            settle();
            check(n_erase, n0 + 1);
            check(e_kind, i);
            check(e_addr, exp[i]);
            check(write_enable_latch, 1'b0);
            wait_idle();
        end
    endtask
    task automatic abort_case(input logic [7:0] q[$], input int tail,
                              input logic [2:0] b, input logic p,
                              input logic set_wel);
        int ne, nw;
        if (set_wel) wren();
        bp = b;
        prot = p;
        ne = n_erase;
        nw = n_we;
        host.frame(q, tail);
        settle();
        check(n_erase, ne);
        check(n_we, nw);
        check({busy, write_enable_latch}, 2'b00);
        bp = 3'h0;
        prot = 1'b0;
    endtask
    task automatic t_aborts();
        abort_case({SFEP_OP_ERASE_4K, 8'h01, 8'h02}, 0,
                   3'h0, 1'b0, 1);
        abort_case({SFEP_OP_CHIP_ERASE_A}, 3, 3'h0, 1'b0, 1);
        abort_case({SFEP_OP_PAGE_PROGRAM, 8'h00, 8'h00}, 0,
                   3'h0, 1'b0, 1);
        abort_case({SFEP_OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h10, 8'h55}, 4,
                   3'h0, 1'b0, 1);
        abort_case({SFEP_OP_CHIP_ERASE_B}, 0, 3'h1, 1'b0, 1);
        lss = 1'b1;
        abl = 1'b1;
        abort_case({SFEP_OP_CHIP_ERASE_A}, 0, 3'h0, 1'b0, 1);
        lss = 1'b0;
        abl = 1'b0;
        abort_case({SFEP_OP_ERASE_64K, 8'h05, 8'h00, 8'h00}, 0,
                   3'h0, 1'b1, 1);
        abort_case({SFEP_OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h20, 8'h00}, 0,
                   3'h0, 1'b1, 1);
        abort_case({SFEP_OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'h20, 8'h00}, 0,
                   3'h0, 1'b0, 0);
    endtask
    task automatic t_program();
        int n0;
        wren();
        n0 = n_we;
        host.frame({SFEP_OP_PAGE_PROGRAM, 8'h00, 8'h00, 8'hFE,
                    8'hA5, 8'h3C, 8'h0F}, 0);
        settle();
        check(busy, 1'b1);
        wait_idle();
        check(paddr, 24'h0000FE);
        check(n_we, n0 + 3);
        check({mem[8'hFE], mem[8'hFF]}, 16'h8118);
        check(mem[8'h00], 8'h0B);
        check({mem[8'h01], mem[8'hFD]}, 16'hDBDB);
    endtask
    initial begin
        #(400_000);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        check({write_enable_latch, busy}, 2'b00);
        t_chip_erase();
        t_block_erase();
        t_aborts();
        t_program();
        complete_run();
    end
endmodule
bind sfep_sequencer sfep_checker chk (
    .CLK(CLK), .RESET(RESET), .BLOCK_PROTECT_FIELD(BLOCK_PROTECT_FIELD),
    .LOCK_SCHEME_SELECT(LOCK_SCHEME_SELECT),
    .ANY_BLOCK_LOCKED(ANY_BLOCK_LOCKED), .MEM_RDATA(MEM_RDATA),
    .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
    .READY_BUSY_FLAG(READY_BUSY_FLAG), .MEM_REQ(MEM_REQ));
`default_nettype wire

// ==== logic/sfep_pin_sync.sv ====
`default_nettype none
module sfep_pin_sync
    import sfep_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic cs_n_pin,
    input  wire logic sck_pin,
    input  wire logic si_pin,
    output sfep_pins_t pins
);

    // ------------------------------------------------------------
    // two-stage synchroniser plus one history stage for edges
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [1:0] s3;
    } sfep_sync_t;

    sfep_sync_t q_reg;
    sfep_sync_t q_next;

    always_comb begin
        q_next    = q_reg;
        q_next.s1 = {cs_n_pin, sck_pin, si_pin};
        q_next.s2 = q_reg.s1;
        q_next.s3 = q_reg.s2[2:1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q_reg <= '{s1: 3'h4, s2: 3'h4, s3: 2'h2};
        end else begin
            q_reg <= q_next;
        end
    end

    assign pins.cs_n     = q_reg.s2[2];
    assign pins.si       = q_reg.s2[0];
    assign pins.sck_rise = q_reg.s2[1] & ~q_reg.s3[0];
    assign pins.cs_fall  = ~q_reg.s2[2] & q_reg.s3[1];
    assign pins.cs_rise  = q_reg.s2[2] & ~q_reg.s3[1];

endmodule
`default_nettype wire

// ==== logic/sfep_pkg.sv ====
`default_nettype none
package sfep_pkg;

    // ------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] SFEP_OP_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] SFEP_OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] SFEP_OP_ERASE_4K      = 8'h20;
    localparam logic [7:0] SFEP_OP_ERASE_32K     = 8'h52;
    localparam logic [7:0] SFEP_OP_ERASE_64K     = 8'hD8;
    localparam logic [7:0] SFEP_OP_CHIP_ERASE_A  = 8'h60;
    localparam logic [7:0] SFEP_OP_CHIP_ERASE_B  = 8'hC7;
    localparam logic [7:0] SFEP_OP_PAGE_PROGRAM  = 8'h02;
    localparam logic [7:0] SFEP_OP_SUSPEND       = 8'h75;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam logic [2:0] SFEP_LAST_BIT      = 3'h7;
    localparam logic [2:0] SFEP_BYTES_OP_ADDR = 3'h4;
    localparam logic [2:0] SFEP_BYTES_MIN_PP  = 3'h5;
    localparam logic [2:0] SFEP_BYTE_CNT_MAX  = 3'h5;
    localparam int         SFEP_PAGE_BYTES    = 256;
    localparam logic [8:0] SFEP_PAGE_FULL     = 9'h100;
    localparam logic [8:0] SFEP_ONE_BYTE      = 9'h001;

    // ------------------------------------------------------------
    // erase region masks on the 24-bit address
    // ------------------------------------------------------------
    localparam logic [23:0] SFEP_MASK_4K  = 24'hFFF000;
    localparam logic [23:0] SFEP_MASK_32K = 24'hFF8000;
    localparam logic [23:0] SFEP_MASK_64K = 24'hFF0000;
    localparam logic [2:0]  SFEP_BP_NONE  = 3'h0;

    // ------------------------------------------------------------
    // self-timed operation times and clock rate
    // ------------------------------------------------------------
    localparam int SFEP_CLK_MHZ              = 200;
    localparam int SFEP_BLOCK_ERASE_TIME_US  = 100;
    localparam int SFEP_CHIP_ERASE_TIME_US   = 1000;
    localparam int SFEP_PAGE_PROGRAM_TIME_US = 50;
    localparam int SFEP_BYTE_PROGRAM_TIME_US = 10;
    localparam int SFEP_BLOCK_ERASE_CYC  = SFEP_BLOCK_ERASE_TIME_US
                                           * SFEP_CLK_MHZ;
    localparam int SFEP_CHIP_ERASE_CYC   = SFEP_CHIP_ERASE_TIME_US
                                           * SFEP_CLK_MHZ;
    localparam int SFEP_PAGE_PROGRAM_CYC = SFEP_PAGE_PROGRAM_TIME_US
                                           * SFEP_CLK_MHZ;
    localparam int SFEP_BYTE_PROGRAM_CYC = SFEP_BYTE_PROGRAM_TIME_US
                                           * SFEP_CLK_MHZ;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SFEP_ERASE_4K,
        SFEP_ERASE_32K,
        SFEP_ERASE_64K,
        SFEP_ERASE_ALL
    } sfep_erase_kind_t;

    typedef enum logic [2:0] {
        SFEP_ST_IDLE,
        SFEP_ST_PROG_RD,
        SFEP_ST_PROG_RDW,
        SFEP_ST_PROG_WR,
        SFEP_ST_WAIT
    } sfep_state_t;

    typedef struct packed {
        logic             we;
        logic             erase;
        sfep_erase_kind_t erase_kind;
        logic [23:0]      addr;
        logic [7:0]       wdata;
    } sfep_mem_req_t;

    typedef struct packed {
        logic cs_n;
        logic si;
        logic sck_rise;
        logic cs_fall;
        logic cs_rise;
    } sfep_pins_t;

endpackage
`default_nettype wire

// ==== logic/sfep_sequencer.sv ====
`default_nettype none
module sfep_sequencer
    import sfep_pkg::*;
#(
    parameter int BLOCK_ERASE_CYCLES  = SFEP_BLOCK_ERASE_CYC,
    parameter int CHIP_ERASE_CYCLES   = SFEP_CHIP_ERASE_CYC,
    parameter int PAGE_PROGRAM_CYCLES = SFEP_PAGE_PROGRAM_CYC,
    parameter int BYTE_PROGRAM_CYCLES = SFEP_BYTE_PROGRAM_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       CS_N,
    input  wire logic       SCK,
    input  wire logic       SI,
    input  wire logic [2:0] BLOCK_PROTECT_FIELD,
    input  wire logic       LOCK_SCHEME_SELECT,
    input  wire logic       ANY_BLOCK_LOCKED,
    input  wire logic       ADDR_PROTECTED,
    input  wire logic [7:0] MEM_RDATA,
    output logic            WRITE_ENABLE_LATCH,
    output logic            READY_BUSY_FLAG,
    output logic [23:0]     PROT_ADDR,
    output sfep_mem_req_t   MEM_REQ
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sfep_state_t                st;
        logic                       in_frame;
        logic                       frame_busy;
        logic [2:0]                 bit_cnt;
        logic [2:0]                 byte_cnt;
        logic [7:0]                 shift;
        logic [7:0]                 opcode;
        logic [23:0]                addr;
        logic [SFEP_PAGE_BYTES-1:0][7:0] pbuf;
        logic [SFEP_PAGE_BYTES-1:0] valid;
        logic [7:0]                 wr_ptr;
        logic [8:0]                 data_cnt;
        logic [7:0]                 idx;
        logic                       write_enable_latch;
        logic                       busy;
        logic                       chip_busy;
        logic [31:0]                timer;
        sfep_mem_req_t              mem;
    } sfep_seq_t;

    sfep_seq_t  q_reg;
    sfep_seq_t  q_next;
    sfep_pins_t pins;
    logic [7:0] byte_in;
    logic       boundary;
    logic       is_block;
    logic       is_chip;
    logic       chip_prot;

    sfep_pin_sync u_sync (
        .clk      (CLK),
        .reset    (RESET),
        .cs_n_pin (CS_N),
        .sck_pin  (SCK),
        .si_pin   (SI),
        .pins     (pins)
    );

    assign byte_in  = {q_reg.shift[6:0], pins.si};
    assign boundary = (q_reg.bit_cnt == 3'h0);
    assign is_block = (q_reg.opcode == SFEP_OP_ERASE_4K)
                    | (q_reg.opcode == SFEP_OP_ERASE_32K)
                    | (q_reg.opcode == SFEP_OP_ERASE_64K);
    assign is_chip  = (q_reg.opcode == SFEP_OP_CHIP_ERASE_A)
                    | (q_reg.opcode == SFEP_OP_CHIP_ERASE_B);
    assign chip_prot = (BLOCK_PROTECT_FIELD != SFEP_BP_NONE)
                     | (LOCK_SCHEME_SELECT & ANY_BLOCK_LOCKED);

    always_comb begin
        q_next           = q_reg;
        q_next.mem.we    = 1'b0;
        q_next.mem.erase = 1'b0;

        // --------------------------------------------------------
        // serial frame capture
        // --------------------------------------------------------
        if (pins.cs_fall) begin
            q_next.in_frame   = 1'b1;
            q_next.frame_busy = q_reg.busy;
            q_next.bit_cnt    = 3'h0;
            q_next.byte_cnt   = 3'h0;
            q_next.opcode     = 8'h00;
            q_next.data_cnt   = 9'h000;
            if (!q_reg.busy) begin
                q_next.valid = '0;
            end
        end else if (q_reg.in_frame && !pins.cs_n && pins.sck_rise) begin
            q_next.shift   = byte_in;
            q_next.bit_cnt = q_reg.bit_cnt + 3'h1;
            if (q_reg.bit_cnt == SFEP_LAST_BIT) begin
                if (q_reg.byte_cnt != SFEP_BYTE_CNT_MAX) begin
                    q_next.byte_cnt = q_reg.byte_cnt + 3'h1;
                end
                unique case (q_reg.byte_cnt)
                    3'h0: q_next.opcode = byte_in;
                    3'h1: q_next.addr[23:16] = byte_in;
                    3'h2: q_next.addr[15:8]  = byte_in;
                    3'h3: begin
                        q_next.addr[7:0] = byte_in;
                        q_next.wr_ptr    = byte_in;
                    end
                    default: begin
                        if (!q_reg.frame_busy) begin
                            // later bytes overwrite older ones in place
                            q_next.pbuf[q_reg.wr_ptr]  = byte_in;
                            q_next.valid[q_reg.wr_ptr] = 1'b1;
                            q_next.wr_ptr = q_reg.wr_ptr + 8'h01;
                            if (q_reg.data_cnt != SFEP_PAGE_FULL) begin
                                q_next.data_cnt = q_reg.data_cnt + 9'h001;
                            end
                        end
                    end
                endcase
                // a frame taken while busy must not disturb running work
                if (q_reg.frame_busy) begin
                    q_next.addr   = q_reg.addr;
                    q_next.wr_ptr = q_reg.wr_ptr;
                end
            end
        end

        // --------------------------------------------------------
        // end of frame: decode and launch
        // --------------------------------------------------------
        if (pins.cs_rise && q_reg.in_frame) begin
            q_next.in_frame = 1'b0;
            if (q_reg.frame_busy) begin
                // commands arriving while busy are dropped; suspend
                // during a whole-array erase in particular has no effect
                if (q_reg.chip_busy
                    && q_reg.opcode == SFEP_OP_SUSPEND) begin
                    q_next.chip_busy = q_reg.chip_busy;
                end
            end else if (q_reg.opcode == SFEP_OP_WRITE_ENABLE
                         && boundary && q_reg.byte_cnt == 3'h1) begin
                q_next.write_enable_latch = 1'b1;
            end else if (q_reg.opcode == SFEP_OP_WRITE_DISABLE
                         && boundary && q_reg.byte_cnt == 3'h1) begin
                q_next.write_enable_latch = 1'b0;
            end else if (is_block && q_reg.write_enable_latch) begin
                if (!boundary) begin
                    q_next.write_enable_latch = 1'b0;
                end else if (q_reg.byte_cnt < SFEP_BYTES_OP_ADDR) begin
                    q_next.write_enable_latch = 1'b0;
                end else if (ADDR_PROTECTED) begin
                    q_next.write_enable_latch = 1'b0;
                end else begin
                    q_next.mem.erase = 1'b1;
                    q_next.write_enable_latch       = 1'b0;
                    q_next.busy      = 1'b1;
                    q_next.st        = SFEP_ST_WAIT;
                    q_next.timer     = 32'(BLOCK_ERASE_CYCLES);
                    unique case (q_reg.opcode)
                        SFEP_OP_ERASE_4K: begin
                            q_next.mem.erase_kind = SFEP_ERASE_4K;
                            q_next.mem.addr = q_reg.addr
                                            & SFEP_MASK_4K;
                        end
                        SFEP_OP_ERASE_32K: begin
                            q_next.mem.erase_kind = SFEP_ERASE_32K;
                            q_next.mem.addr = q_reg.addr
                                            & SFEP_MASK_32K;
                        end
                        default: begin
                            q_next.mem.erase_kind = SFEP_ERASE_64K;
                            q_next.mem.addr = q_reg.addr
                                            & SFEP_MASK_64K;
                        end
                    endcase
                end
            end else if (is_chip && q_reg.write_enable_latch) begin
                if (!boundary) begin
                    q_next.write_enable_latch = 1'b0;
                end else if (chip_prot) begin
                    q_next.write_enable_latch = 1'b0;
                end else begin
                    // opcode alone suffices; launched on the rising select
                    q_next.mem.erase      = 1'b1;
                    q_next.mem.erase_kind = SFEP_ERASE_ALL;
                    q_next.mem.addr       = 24'h000000;
                    q_next.write_enable_latch            = 1'b0;
                    q_next.busy           = 1'b1;
                    q_next.chip_busy      = 1'b1;
                    q_next.st             = SFEP_ST_WAIT;
                    q_next.timer          = 32'(CHIP_ERASE_CYCLES);
                end
            end else if (q_reg.opcode == SFEP_OP_PAGE_PROGRAM
                         && q_reg.write_enable_latch) begin
                if (!boundary) begin
                    q_next.write_enable_latch = 1'b0;
                end else if (q_reg.byte_cnt < SFEP_BYTES_MIN_PP) begin
                    q_next.write_enable_latch = 1'b0;
                end else if (ADDR_PROTECTED) begin
                    q_next.write_enable_latch = 1'b0;
                end else begin
                    q_next.busy  = 1'b1;
                    q_next.write_enable_latch   = 1'b0;
                    q_next.idx   = 8'h00;
                    q_next.st    = SFEP_ST_PROG_RD;
                    q_next.timer = (q_reg.data_cnt == SFEP_ONE_BYTE)
                                 ? 32'(BYTE_PROGRAM_CYCLES)
                                 : 32'(PAGE_PROGRAM_CYCLES);
                end
            end
        end

        // --------------------------------------------------------
        // self-timed array work
        // --------------------------------------------------------
        if (q_reg.timer != 32'h00000000) begin
            q_next.timer = q_reg.timer - 32'h00000001;
        end
        unique case (q_reg.st)
            SFEP_ST_IDLE: begin
            end
            SFEP_ST_PROG_RD: begin
                if (q_reg.valid[q_reg.idx]) begin
                    q_next.mem.addr = {q_reg.addr[23:8], q_reg.idx};
                    q_next.st       = SFEP_ST_PROG_RDW;
                end else begin
                    // untouched locations are never written
                    q_next.idx = q_reg.idx + 8'h01;
                    if (q_reg.idx == 8'hFF) begin
                        q_next.st = SFEP_ST_WAIT;
                    end
                end
            end
            SFEP_ST_PROG_RDW: begin
                q_next.st = SFEP_ST_PROG_WR;
            end
            SFEP_ST_PROG_WR: begin
                q_next.mem.we    = 1'b1;
                q_next.mem.wdata = MEM_RDATA
                                 & q_reg.pbuf[q_reg.idx];
                q_next.idx       = q_reg.idx + 8'h01;
                q_next.st        = (q_reg.idx == 8'hFF)
                                 ? SFEP_ST_WAIT : SFEP_ST_PROG_RD;
            end
            SFEP_ST_WAIT: begin
                if (q_reg.timer <= 32'h00000001) begin
                    q_next.busy      = 1'b0;
                    q_next.chip_busy = 1'b0;
                    q_next.st        = SFEP_ST_IDLE;
                end
            end
            default: begin
                q_next.st = SFEP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            q_reg    <= '0;
            q_reg.st <= SFEP_ST_IDLE;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        WRITE_ENABLE_LATCH = q_reg.write_enable_latch;
        READY_BUSY_FLAG    = q_reg.busy;
        PROT_ADDR          = q_reg.addr;
        MEM_REQ            = q_reg.mem;
    end

endmodule
`default_nettype wire
